// *** common/acia_defines.vh ***
// Purpose: constants for the async serial communications adapter
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef ACIA_DEFINES_VH
`define ACIA_DEFINES_VH
// ==========================================
// Register select codes {hi, lo}
`define RSEL_DATA 2'h0
`define RSEL_STAT 2'h1
`define RSEL_CMD 2'h2
`define RSEL_CTRL 2'h3
// ==========================================
// Command register fields
`define CMD_PMODE_HI 7
`define CMD_PMODE_LO 6
`define CMD_PAR_EN 5
`define CMD_ECHO 4
`define CMD_TXC_HI 3
`define CMD_TXC_LO 2
`define CMD_RXIRQ_DIS 1
`define CMD_DTR 0
`define CMD_PRESET_MASK 8'hE0
// ==========================================
// Control register fields
`define CTL_STOP 7
`define CTL_WL_HI 6
`define CTL_WL_LO 5
`define CTL_RXSRC 4
`define CTL_BAUD_HI 3
`define CTL_BAUD_LO 0
// ==========================================
// Status register bit positions
`define ST_IRQ 7
`define ST_DSR 6
`define ST_DCD 5
`define ST_TDRE 4
`define ST_RDRF 3
`define ST_OVR 2
`define ST_FE 1
`define ST_PE 0
// ==========================================
// Reset values
`define CMD_RESET 8'h00
`define CTL_RESET 8'h00
// ==========================================
// Bit timing in 16x ticks
`define TICK_LAST 5'h0F
`define TICK_MID 5'h07
`define STOP_ONE_HALF 5'h17
`define STOP_TWO 5'h1F
`endif

// *** dv/async_serial_comm_adapter_assertions.sv ***
// Purpose: port-level checks for the serial adapter
// Assumes: bound to the top module, one clock domain
// Notes: registered outputs may lag a write by up to two cycles
`timescale 1ns/10ps
`default_nettype none
module async_serial_comm_adapter_assertions (
   input wire logic MCLK_IN, // Clock
   input wire logic RESET_IN, // Reset
   input wire logic BUS_STROBE_IN, // Access strobe
   input wire logic CHIP_SELECT_POS_IN, // Select high
   input wire logic CHIP_SELECT_NEG_N_IN, // Select low
   input wire logic READ_IN, // Direction
   input wire logic [7:0] DATA_OUT, // Read data
   input wire logic DATA_OE_OUT, // Read enable
   input wire logic IRQ_N_OUT, // Irq level
   input wire logic RX_16X_CLOCK_PIN_OUT, // Tick out
   input wire logic RX_16X_CLOCK_PIN_OE_OUT, // Tick enable
   input wire logic TXD_OUT, // Serial out
   input wire logic RTS_N_OUT, // Request
   input wire logic DTR_N_OUT // Ready
);
   // ==========================================
   // Access decode
   wire sel = BUS_STROBE_IN && CHIP_SELECT_POS_IN && !CHIP_SELECT_NEG_N_IN;
   wire rd = sel && READ_IN;
   wire wr = sel && !READ_IN;
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (RESET_IN);
   // ==========================================
   // Checks
   chk_read_answer: assert property (rd |=> DATA_OE_OUT)
      else $error("read enable missing");
   chk_drive_cause: assert property (DATA_OE_OUT |-> $past(rd))
      else $error("data driven without read");
   chk_unsel_quiet: assert property (BUS_STROBE_IN && !sel |=> !DATA_OE_OUT)
      else $error("unselected access answered");
   chk_data_holds: assert property (!DATA_OE_OUT && !$past(RESET_IN) |-> $stable(DATA_OUT))
      else $error("read data moved between reads");
   chk_reset_state: assert property (disable iff (1'b0) RESET_IN |=> TXD_OUT && RTS_N_OUT
      && DTR_N_OUT && !DATA_OE_OUT && !RX_16X_CLOCK_PIN_OE_OUT)
      else $error("outputs not at reset state");
   chk_modem_lines: assert property ($changed(RTS_N_OUT) || $changed(DTR_N_OUT) |->
      $past(wr) || $past(wr, 2) || $past(RESET_IN))
      else $error("modem line moved without write");
   chk_rxc_enable: assert property ($changed(RX_16X_CLOCK_PIN_OE_OUT) |->
      $past(wr) || $past(wr, 2) || $past(RESET_IN))
      else $error("clock pin enable moved without write");
   chk_tick_pulse: assert property (RX_16X_CLOCK_PIN_OUT |=> !RX_16X_CLOCK_PIN_OUT)
      else $error("tick pulse longer than one cycle");
   chk_irq_open: assert property (IRQ_N_OUT == 1'b0)
      else $error("irq level not low");
endmodule
bind async_serial_comm_adapter async_serial_comm_adapter_assertions u_chk (
   .MCLK_IN(MCLK_IN),
   .RESET_IN(RESET_IN),
   .BUS_STROBE_IN(BUS_STROBE_IN),
   .CHIP_SELECT_POS_IN(CHIP_SELECT_POS_IN),
   .CHIP_SELECT_NEG_N_IN(CHIP_SELECT_NEG_N_IN),
   .READ_IN(READ_IN),
   .DATA_OUT(DATA_OUT),
   .DATA_OE_OUT(DATA_OE_OUT),
   .IRQ_N_OUT(IRQ_N_OUT),
   .RX_16X_CLOCK_PIN_OUT(RX_16X_CLOCK_PIN_OUT),
   .RX_16X_CLOCK_PIN_OE_OUT(RX_16X_CLOCK_PIN_OE_OUT),
   .TXD_OUT(TXD_OUT),
   .RTS_N_OUT(RTS_N_OUT),
   .DTR_N_OUT(DTR_N_OUT)
);
`default_nettype wire

// *** dv/async_serial_comm_adapter_bench.sv ***
// Purpose: self-checking bench for the serial adapter
// Assumes: both directions run from the 16x source of the modem model
// Notes: bus accesses are one strobe each
`timescale 1ns/10ps
`default_nettype none
`include "acia_defines.vh"
module async_serial_comm_adapter_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic stb = 1'b0;
   logic cs_pos = 1'b1;
   logic cs_neg_n = 1'b0;
   logic sel_ok = 1'b1;
   logic [1:0] rs = 2'h0;
   logic rd = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic cts_n = 1'b0;
   logic dsr_n = 1'b0;
   logic dcd_n = 1'b0;
   wire [7:0] rdata;
   wire oe;
   wire irq_oe;
   wire rxc_oe;
   wire txd;
   wire rts_n;
   wire dtr_n;
   wire xtal;
   wire rxd;
   int err_total = 0;
   int tests_run = 0;
   logic [11:0] f;
   logic ok;
   int t;
   logic [7:0] t_ctrl [0:6] = '{8'h00, 8'hE0, 8'hA0, 8'hC0, 8'h60, 8'h80, 8'hE0};
   logic [7:0] t_cmd [0:6] = '{8'h0B, 8'h0B, 8'h2B, 8'h6B, 8'hAB, 8'hEB, 8'h2B};
   logic [7:0] t_dat [0:6] = '{8'hA5, 8'h3A, 8'h6D, 8'h2C, 8'h13, 8'hC7, 8'h15};
   always #20 clk = ~clk;
   async_serial_comm_adapter u_async_serial_comm_adapter (
      .MCLK_IN(clk),
      .RESET_IN(rst),
      .BUS_STROBE_IN(stb),
      .CHIP_SELECT_POS_IN(cs_pos),
      .CHIP_SELECT_NEG_N_IN(cs_neg_n),
      .REG_SELECT_HI_IN(rs[1]),
      .REG_SELECT_LO_IN(rs[0]),
      .READ_IN(rd),
      .DATA_IN(wdata),
      .DATA_OUT(rdata),
      .DATA_OE_OUT(oe),
      .IRQ_N_OUT(),
      .IRQ_OE_OUT(irq_oe),
      .CRYSTAL_IN(xtal),
      .RX_16X_CLOCK_PIN_IN(xtal),
      .RX_16X_CLOCK_PIN_OUT(),
      .RX_16X_CLOCK_PIN_OE_OUT(rxc_oe),
      .TXD_OUT(txd),
      .RXD_IN(rxd),
      .CTS_N_IN(cts_n),
      .RTS_N_OUT(rts_n),
      .DTR_N_OUT(dtr_n),
      .DSR_N_IN(dsr_n),
      .DCD_N_IN(dcd_n)
   );
   serial_modem_model u_serial_modem_model (
      .clk_in(clk),
      .txd_in(txd),
      .crystal_out(xtal),
      .rxd_out(rxd)
   );
   // ==========================================
   // Compare, bus and frame tasks
   task automatic check_val(input string what, input logic [11:0] exp, input logic [11:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_gap(input int lo, input int got);
      tests_run++;
      if (got < lo || got > lo + 8) begin
         err_total++;
         $display("wrong value frame gap expected %0d seen %0d", lo, got);
      end
   endtask
   task automatic bus_cycle(input logic [1:0] sel, input logic r, input logic [7:0] d);
      @(posedge clk);
      stb <= 1'b1;
      cs_neg_n <= !sel_ok;
      rs <= sel;
      rd <= r;
      wdata <= d;
      @(posedge clk);
      stb <= 1'b0;
      #1;
   endtask
   task automatic bus_write(input logic [1:0] sel, input logic [7:0] d);
      bus_cycle(sel, 1'b0, d);
   endtask
   task automatic bus_read_chk(input string what, input logic [1:0] sel, input logic [7:0] exp);
      bus_cycle(sel, 1'b1, 8'h00);
      check_val(what, {4'h1, exp}, {3'h0, oe, rdata});
   endtask
   task automatic rx_frame(input logic [7:0] d, input logic bad_par, input logic bad_stop);
      u_serial_modem_model.send_frame({2'h0, !bad_stop, (^d) ^ bad_par, d}, 10);
   endtask
   task automatic tx_case(input logic [7:0] c, input logic [7:0] m, input logic [7:0] d);
      int wl;
      int pe;
      int ticks;
      int t1;
      int t2;
      logic p;
      logic ok1;
      logic ok2;
      logic [11:0] f1;
      logic [11:0] f2;
      logic [11:0] exp;
      wl = 8 - c[6:5];
      pe = m[5];
      ticks = 16 * (1 + wl + pe) + (c[7] ? ((wl == 5 && pe == 0) ? 24 : 32) : 16);
      exp = {4'h0, d} & ((12'h001 << wl) - 12'h001);
      p = m[7] ? ~m[6] : (^exp) ^ ~m[6];
      if (pe) exp[wl] = p;
      exp[wl + pe] = 1'b1;
      bus_write(`RSEL_CTRL, c);
      bus_write(`RSEL_CMD, m);
      fork
         u_serial_modem_model.get_frame(wl + pe + 1, 400, f1, ok1, t1);
         begin
            bus_write(`RSEL_DATA, d);
            repeat (20) @(posedge clk);
            bus_write(`RSEL_DATA, d);
            bus_read_chk("tx holding full", `RSEL_STAT, 8'h00);
         end
      join
      u_serial_modem_model.get_frame(wl + pe + 1, 400, f2, ok2, t2);
      check_val("tx frame", exp, f1);
      check_val("tx second frame", exp, f2);
      check_gap(ticks * 4, t2 - t1);
      repeat (160) @(posedge clk);
   endtask
   task automatic give_verdict();
      if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================================
   // Test sequence
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      bus_read_chk("status reset", `RSEL_STAT, 8'h10);
      bus_read_chk("cmd reset", `RSEL_CMD, 8'h00);
      check_val("modem lines reset", 12'h003, {10'h0, rts_n, dtr_n});
      sel_ok = 1'b0;
      bus_write(`RSEL_CTRL, 8'hFF);
      sel_ok = 1'b1;
      bus_read_chk("ctrl unselected", `RSEL_CTRL, 8'h00);
      bus_write(`RSEL_CMD, 8'h0B);
      bus_read_chk("cmd readback", `RSEL_CMD, 8'h0B);
      check_val("modem lines on", 12'h000, {10'h0, rts_n, dtr_n});
      for (int i = 0; i < 7; i++) tx_case(t_ctrl[i], t_cmd[i], t_dat[i]);
      bus_write(`RSEL_CTRL, 8'h00);
      bus_write(`RSEL_CMD, 8'h0B);
      fork
         u_serial_modem_model.get_frame(9, 100, f, ok, t);
         begin
            bus_write(`RSEL_DATA, 8'h96);
            repeat (200) @(posedge clk);
            cts_n <= 1'b1;
         end
      join
      check_val("cts late drop", 12'h196, f);
      bus_write(`RSEL_DATA, 8'h69);
      u_serial_modem_model.get_frame(9, 400, f, ok, t);
      check_val("cts hold", 12'h000, {11'h0, ok});
      @(posedge clk);
      cts_n <= 1'b0;
      u_serial_modem_model.get_frame(9, 100, f, ok, t);
      check_val("cts resume", 12'h169, f);
      repeat (100) @(posedge clk);
      bus_write(`RSEL_CMD, 8'h7B);
      fork
         rx_frame(8'hC3, 1'b0, 1'b0);
         u_serial_modem_model.get_frame(10, 200, f, ok, t);
      join
      check_val("echo frame", {3'h1, ^8'hC3, 8'hC3}, f);
      bus_read_chk("rx external clock", `RSEL_DATA, 8'hC3);
      bus_write(`RSEL_CTRL, 8'h10);
      bus_write(`RSEL_CMD, 8'h6B);
      check_val("rx clock drive", 12'h001, {11'h0, rxc_oe});
      rx_frame(8'h3C, 1'b0, 1'b0);
      bus_read_chk("rx full", `RSEL_STAT, 8'h18);
      bus_read_chk("rx data", `RSEL_DATA, 8'h3C);
      bus_read_chk("rx emptied", `RSEL_STAT, 8'h10);
      rx_frame(8'h11, 1'b0, 1'b0);
      rx_frame(8'h22, 1'b0, 1'b0);
      bus_read_chk("overrun", `RSEL_STAT, 8'h1C);
      bus_write(`RSEL_STAT, 8'hFF);
      bus_read_chk("soft reset status", `RSEL_STAT, 8'h98);
      check_val("irq drive", 12'h001, {11'h0, irq_oe});
      bus_read_chk("soft reset cmd", `RSEL_CMD, 8'h60);
      bus_read_chk("soft reset ctrl", `RSEL_CTRL, 8'h10);
      bus_read_chk("overrun keeps old", `RSEL_DATA, 8'h11);
      bus_write(`RSEL_CMD, 8'h6B);
      rx_frame(8'h5A, 1'b1, 1'b0);
      bus_read_chk("parity error", `RSEL_STAT, 8'h19);
      bus_read_chk("parity data", `RSEL_DATA, 8'h5A);
      rx_frame(8'hA6, 1'b0, 1'b1);
      bus_read_chk("framing error", `RSEL_STAT, 8'h1A);
      bus_read_chk("framing data", `RSEL_DATA, 8'hA6);
      @(posedge clk);
      dsr_n <= 1'b1;
      repeat (4) @(posedge clk);
      bus_read_chk("status set ready", `RSEL_STAT, 8'hD2);
      bus_read_chk("status irq cleared", `RSEL_STAT, 8'h52);
      give_verdict();
   end
   initial begin
      repeat (80000) @(posedge clk);
      err_total++;
      give_verdict();
   end
endmodule
`default_nettype wire

// *** dv/serial_modem_model.sv ***
// Purpose: modem side model, 16x source and serial frames
// Assumes: 16x clock is the system clock over 4, a bit is 64 cycles
// Notes: the 16x source is an oscillator and runs free
`timescale 1ns/10ps
`default_nettype none
module serial_modem_model (
   input wire logic clk_in, // System clock
   input wire logic txd_in, // Adapter serial out
   output logic crystal_out, // 16x source
   output logic rxd_out // Serial to adapter
);
   logic [1:0] div_reg;
   int cyc;
   initial begin
      div_reg = 2'h0;
      cyc = 0;
      crystal_out = 1'b0;
      rxd_out = 1'b1;
   end
   always @(posedge clk_in) begin
      div_reg <= div_reg + 2'h1;
      crystal_out <= div_reg[1];
      cyc <= cyc + 1;
   end
   // ==========================================
   // Frame sender: low start, bits LSB first, then idle high
   task automatic send_frame(input logic [11:0] f, input int n);
      @(posedge clk_in);
      rxd_out <= 1'b0;
      repeat (64) @(posedge clk_in);
      for (int i = 0; i < n; i++) begin
         rxd_out <= f[i];
         repeat (64) @(posedge clk_in);
      end
      rxd_out <= 1'b1;
      repeat (64) @(posedge clk_in);
   endtask
   // ==========================================
   // Frame catcher: waits for a start, samples each bit mid-cell
   task automatic get_frame(input int n, input int lim, output logic [11:0] f,
      output logic ok, output int t);
      f = 12'h000;
      ok = 1'b0;
      for (int i = 0; i < lim && !ok; i++) begin
         @(posedge clk_in);
         #1 ok = !txd_in;
      end
      t = cyc;
      if (!ok) return;
      repeat (32) @(posedge clk_in);
      for (int i = 0; i < n; i++) begin
         repeat (64) @(posedge clk_in);
         #1 f[i] = txd_in;
      end
   endtask
endmodule
`default_nettype wire

// *** hw/acia_rx.v ***
// Purpose: serial receiver shift section with 16x oversampling
// Assumes: tick_in is a one-cycle pulse at 16 times the bit rate
// Notes: results held until the next frame completes
`timescale 1ns/10ps
`default_nettype none
`include "acia_defines.vh"
module acia_rx (
   input wire clk_in,         // System clock
   input wire rst_in,         // Synchronous reset, high
   input wire tick_in,        // 16x bit-rate tick
   input wire rxd_in,         // Serial input, idle high
   input wire [1:0] wl_in,    // Word length code, 0 = 8 bits
   input wire par_en_in,      // Parity checking enabled
   input wire [1:0] pmode_in, // Parity mode
   output reg done_out,       // Frame complete pulse
   output reg [7:0] data_out, // Received character
   output reg ferr_out,       // Framing error of last frame
   output reg perr_out        // Parity error of last frame
);
   localparam RX_IDLE = 3'h0;
   localparam RX_START = 3'h1;
   localparam RX_DATA = 3'h2;
   localparam RX_PAR = 3'h3;
   localparam RX_STOP = 3'h4;
   reg [2:0] state_reg;
   reg [4:0] cnt_reg;
   reg [2:0] bit_reg;
   reg [7:0] shift_reg;
   reg rxd_prev_reg;
   reg par_bad_reg;
   wire [7:0] word = shift_reg >> wl_in;
   wire [2:0] last_bit = 3'h7 - {1'b0, wl_in};
   wire par_expect = pmode_in[1] ? ~pmode_in[0] : (pmode_in[0] ? ^word : ~^word);
   // ==========================================
   // Frame state machine
   always @(posedge clk_in) begin
      if (rst_in) begin
         state_reg <= RX_IDLE;
         cnt_reg <= 5'h00;
         bit_reg <= 3'h0;
         shift_reg <= 8'h00;
         rxd_prev_reg <= 1'b1;
         par_bad_reg <= 1'b0;
         done_out <= 1'b0;
         data_out <= 8'h00;
         ferr_out <= 1'b0;
         perr_out <= 1'b0;
      end else begin
         rxd_prev_reg <= rxd_in;
         done_out <= 1'b0;
         case (state_reg)
            RX_IDLE: begin
               if (rxd_prev_reg && !rxd_in) begin
                  state_reg <= RX_START;
                  cnt_reg <= 5'h00;
               end
            end
            default: begin
               if (tick_in) begin
                  cnt_reg <= cnt_reg + 5'h01;
                  if (state_reg == RX_START && cnt_reg == `TICK_MID) begin
                     cnt_reg <= 5'h00;
                     bit_reg <= 3'h0;
                     par_bad_reg <= 1'b0;
                     state_reg <= rxd_in ? RX_IDLE : RX_DATA;
                  end else if (state_reg != RX_START && cnt_reg == `TICK_LAST) begin
                     cnt_reg <= 5'h00;
                     case (state_reg)
                        RX_DATA: begin
                           shift_reg <= {rxd_in, shift_reg[7:1]};
                           bit_reg <= bit_reg + 3'h1;
                           if (bit_reg == last_bit) begin
                              state_reg <= par_en_in ? RX_PAR : RX_STOP;
                           end
                        end
                        RX_PAR: begin
                           par_bad_reg <= rxd_in ^ par_expect;
                           state_reg <= RX_STOP;
                        end
                        default: begin
                           data_out <= word;
                           ferr_out <= ~rxd_in;
                           perr_out <= par_bad_reg;
                           done_out <= 1'b1;
                           state_reg <= RX_IDLE;
                        end
                     endcase
                  end
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// *** hw/async_serial_comm_adapter.v ***
// Purpose: asynchronous serial communications adapter, bus side and serial side
// Assumes: all inputs synchronous to MCLK_IN; BUS_STROBE_IN marks one access
// Notes: crystal_in is sampled and must stay below half of MCLK_IN
//
// Contract
// - Transmit rate is one of fifteen generator rates or external clock over sixteen.
// - Receive rate is transmit rate or external receive clock over sixteen.
// - Character length programmable five to eight bits both directions.
// - Parity even, odd or none; generated on transmit, checked on receive.
// - Transmit stop bits one, one and a half, or two.
// - Deferred variant finishes current character when clear-to-send drops.
// - Command register holds parity, echo, transmit irq, RTS, receive irq, DTR.
// - Control register holds stop bits, length, receive clock source, baud rate.
// - Status shows irq, DSR, DCD, buffer states, overrun, framing, parity errors.
// - Transmitter and receiver run independently, each holding register plus shifter.
// - Echo mode retransmits received serial data on the output.
// - Serial logic supports rates up to 250000 baud.
// - Register select decodes data, status or programmed reset, command, control.
// - Programmed reset clears command bits four to zero and status bit two.
// - Hardware reset clears command, control, status; sets transmitter empty.
`timescale 1ns/10ps
`default_nettype none
`include "acia_defines.vh"
module async_serial_comm_adapter #(
   parameter DEFER_CTS = 1 // 1 selects deferred clear-to-send handling
) (
   input wire MCLK_IN,                  // System clock, 25 MHz
   input wire RESET_IN,                 // Synchronous hardware reset, high
   input wire BUS_STROBE_IN,            // One-cycle bus access strobe
   input wire CHIP_SELECT_POS_IN,       // Select, active high
   input wire CHIP_SELECT_NEG_N_IN,     // Select, active low
   input wire REG_SELECT_HI_IN,         // Register select high bit
   input wire REG_SELECT_LO_IN,         // Register select low bit
   input wire READ_IN,                  // High read, low write
   input wire [7:0] DATA_IN,            // Write data
   output reg [7:0] DATA_OUT,           // Read data
   output reg DATA_OE_OUT,              // Read data drive enable
   output reg IRQ_N_OUT,                // Interrupt pin level, constant low
   output reg IRQ_OE_OUT,               // Interrupt pull-down enable
   input wire CRYSTAL_IN,               // Baud source clock, sampled
   input wire RX_16X_CLOCK_PIN_IN,      // External receive 16x clock
   output reg RX_16X_CLOCK_PIN_OUT,     // Internal 16x clock out
   output reg RX_16X_CLOCK_PIN_OE_OUT,  // Drive enable for that pin
   output reg TXD_OUT,                  // Serial output
   input wire RXD_IN,                   // Serial input
   input wire CTS_N_IN,                 // Clear to send, low
   output reg RTS_N_OUT,                // Request to send, low
   output reg DTR_N_OUT,                // Data terminal ready, low
   input wire DSR_N_IN,                 // Data set ready, low
   input wire DCD_N_IN                  // Carrier detect, low
);
   localparam TX_IDLE = 3'h0;
   localparam TX_START = 3'h1;
   localparam TX_DATA = 3'h2;
   localparam TX_PAR = 3'h3;
   localparam TX_STOP = 3'h4;
   reg [7:0] cmd_reg, ctrl_reg, tdr_reg, rdr_reg;
   reg tdre_reg, rdrf_reg, ovr_reg, fe_reg, pe_reg, chg_reg, irq_reg;
   reg dsr_prev_reg, dcd_prev_reg, xtal_prev_reg, rxc_prev_reg;
   reg [11:0] div_cnt_reg;
   reg gen_tick_reg, rxc_tick_reg;
   reg [2:0] tx_state_reg;
   reg [4:0] tx_cnt_reg;
   reg [2:0] tx_bit_reg;
   reg [7:0] tx_shift_reg;
   reg tx_par_reg;
   reg [11:0] div_sel;
   reg tx_line;
   wire rx_done;
   wire [7:0] rx_data;
   wire rx_ferr, rx_perr;
   wire [1:0] wl = ctrl_reg[`CTL_WL_HI:`CTL_WL_LO];
   wire [1:0] pmode = cmd_reg[`CMD_PMODE_HI:`CMD_PMODE_LO];
   wire [1:0] txc = cmd_reg[`CMD_TXC_HI:`CMD_TXC_LO];
   wire [3:0] baud = ctrl_reg[`CTL_BAUD_HI:`CTL_BAUD_LO];
   wire [1:0] rsel = {REG_SELECT_HI_IN, REG_SELECT_LO_IN};
   wire sel = BUS_STROBE_IN & CHIP_SELECT_POS_IN & ~CHIP_SELECT_NEG_N_IN;
   wire wr = sel & ~READ_IN;
   wire rd = sel & READ_IN;
   wire xtal_rise = CRYSTAL_IN & ~xtal_prev_reg;
   wire rx_tick = ctrl_reg[`CTL_RXSRC] ? gen_tick_reg : rxc_tick_reg;
   wire tx_tick = gen_tick_reg;
   wire cts_ok = ~CTS_N_IN;
   wire [7:0] tx_word = tdr_reg & (8'hFF >> wl);
   wire tx_pbit = pmode[1] ? ~pmode[0] : (pmode[0] ? ^tx_word : ~^tx_word);
   wire [2:0] tx_last = 3'h7 - {1'b0, wl};
   wire [4:0] stop_end = ~ctrl_reg[`CTL_STOP] ? `TICK_LAST :
      ((wl == 2'h3 && !cmd_reg[`CMD_PAR_EN]) ? `STOP_ONE_HALF : `STOP_TWO);
   wire tx_irq_en = (txc == 2'h1);
   wire rx_irq_en = ~cmd_reg[`CMD_RXIRQ_DIS];
   wire modem_chg = (DSR_N_IN ^ dsr_prev_reg) | (DCD_N_IN ^ dcd_prev_reg);
   wire [7:0] status = {irq_reg, DSR_N_IN, DCD_N_IN, tdre_reg, rdrf_reg,
      ovr_reg, fe_reg, pe_reg};
   // ==========================================
   // Baud generator: 16x tick per divisor of crystal edges
   always @* begin
      case (baud)
         4'h1: div_sel = 12'h900;
         4'h2: div_sel = 12'h600;
         4'h3: div_sel = 12'h417;
         4'h4: div_sel = 12'h358;
         4'h5: div_sel = 12'h300;
         4'h6: div_sel = 12'h180;
         4'h7: div_sel = 12'h0C0;
         4'h8: div_sel = 12'h060;
         4'h9: div_sel = 12'h040;
         4'hA: div_sel = 12'h030;
         4'hB: div_sel = 12'h020;
         4'hC: div_sel = 12'h018;
         4'hD: div_sel = 12'h010;
         4'hE: div_sel = 12'h00C;
         4'hF: div_sel = 12'h006;
         default: div_sel = 12'h001;
      endcase
   end
   always @(posedge MCLK_IN) begin
      if (RESET_IN) begin
         xtal_prev_reg <= 1'b0;
         rxc_prev_reg <= 1'b0;
         div_cnt_reg <= 12'h000;
         gen_tick_reg <= 1'b0;
         rxc_tick_reg <= 1'b0;
      end else begin
         xtal_prev_reg <= CRYSTAL_IN;
         rxc_prev_reg <= RX_16X_CLOCK_PIN_IN;
         rxc_tick_reg <= RX_16X_CLOCK_PIN_IN & ~rxc_prev_reg & ~ctrl_reg[`CTL_RXSRC];
         gen_tick_reg <= 1'b0;
         if (xtal_rise) begin
            if (div_cnt_reg >= div_sel - 12'h001) begin
               div_cnt_reg <= 12'h000;
               gen_tick_reg <= 1'b1;
            end else begin
               div_cnt_reg <= div_cnt_reg + 12'h001;
            end
         end
      end
   end
   // ==========================================
   // Bus registers and status flags
   always @(posedge MCLK_IN) begin
      if (RESET_IN) begin
         cmd_reg <= `CMD_RESET;
         ctrl_reg <= `CTL_RESET;
         tdr_reg <= 8'h00;
         rdr_reg <= 8'h00;
         tdre_reg <= 1'b1;
         rdrf_reg <= 1'b0;
         ovr_reg <= 1'b0;
         fe_reg <= 1'b0;
         pe_reg <= 1'b0;
         chg_reg <= 1'b0;
         irq_reg <= 1'b0;
         dsr_prev_reg <= DSR_N_IN;
         dcd_prev_reg <= DCD_N_IN;
         DATA_OUT <= 8'h00;
         DATA_OE_OUT <= 1'b0;
      end else begin
         dsr_prev_reg <= DSR_N_IN;
         dcd_prev_reg <= DCD_N_IN;
         DATA_OE_OUT <= rd;
         if (rd) begin
            case (rsel)
               `RSEL_DATA: DATA_OUT <= rdr_reg;
               `RSEL_STAT: DATA_OUT <= status;
               `RSEL_CMD: DATA_OUT <= cmd_reg;
               default: DATA_OUT <= ctrl_reg;
            endcase
         end
         if (wr) begin
            case (rsel)
               `RSEL_DATA: tdr_reg <= DATA_IN;
               `RSEL_STAT: cmd_reg <= cmd_reg & `CMD_PRESET_MASK;
               `RSEL_CMD: cmd_reg <= DATA_IN;
               default: ctrl_reg <= DATA_IN;
            endcase
         end
         if (wr && rsel == `RSEL_DATA) begin
            tdre_reg <= 1'b0;
         end else if (tx_state_reg == TX_IDLE && !tdre_reg && cts_ok && tx_tick) begin
            tdre_reg <= 1'b1;
         end
         if (rd && rsel == `RSEL_DATA) begin
            rdrf_reg <= 1'b0;
            ovr_reg <= 1'b0;
         end
         if (wr && rsel == `RSEL_STAT) begin
            ovr_reg <= 1'b0;
         end
         if (rx_done) begin
            if (rdrf_reg && !(rd && rsel == `RSEL_DATA)) begin
               ovr_reg <= 1'b1;
            end else begin
               rdr_reg <= rx_data;
               rdrf_reg <= 1'b1;
               fe_reg <= rx_ferr;
               pe_reg <= rx_perr & cmd_reg[`CMD_PAR_EN];
            end
         end
         if (modem_chg) begin
            chg_reg <= 1'b1;
         end else if (rd && rsel == `RSEL_STAT) begin
            chg_reg <= 1'b0;
         end
         irq_reg <= (rdrf_reg & rx_irq_en) | (tdre_reg & tx_irq_en) | chg_reg | modem_chg;
      end
   end
   // ==========================================
   // Transmitter
   always @* begin
      case (tx_state_reg)
         TX_START: tx_line = 1'b0;
         TX_DATA: tx_line = tx_shift_reg[0];
         TX_PAR: tx_line = tx_par_reg;
         default: tx_line = 1'b1;
      endcase
   end
   always @(posedge MCLK_IN) begin
      if (RESET_IN) begin
         tx_state_reg <= TX_IDLE;
         tx_cnt_reg <= 5'h00;
         tx_bit_reg <= 3'h0;
         tx_shift_reg <= 8'h00;
         tx_par_reg <= 1'b0;
      end else if (DEFER_CTS == 0 && !cts_ok && tx_state_reg != TX_IDLE) begin
         tx_state_reg <= TX_IDLE;
      end else if (tx_state_reg == TX_IDLE) begin
         if (!tdre_reg && cts_ok && tx_tick) begin
            tx_shift_reg <= tx_word;
            tx_par_reg <= tx_pbit;
            tx_cnt_reg <= 5'h00;
            tx_bit_reg <= 3'h0;
            tx_state_reg <= TX_START;
         end
      end else if (tx_tick) begin
         tx_cnt_reg <= tx_cnt_reg + 5'h01;
         if (tx_state_reg == TX_STOP) begin
            if (tx_cnt_reg == stop_end) begin
               tx_state_reg <= TX_IDLE;
            end
         end else if (tx_cnt_reg == `TICK_LAST) begin
            tx_cnt_reg <= 5'h00;
            case (tx_state_reg)
               TX_START: tx_state_reg <= TX_DATA;
               TX_DATA: begin
                  tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                  tx_bit_reg <= tx_bit_reg + 3'h1;
                  if (tx_bit_reg == tx_last) begin
                     tx_state_reg <= cmd_reg[`CMD_PAR_EN] ? TX_PAR : TX_STOP;
                  end
               end
               default: tx_state_reg <= TX_STOP;
            endcase
         end
      end
   end
   // ==========================================
   // Registered pin outputs
   always @(posedge MCLK_IN) begin
      if (RESET_IN) begin
         TXD_OUT <= 1'b1;
         RTS_N_OUT <= 1'b1;
         DTR_N_OUT <= 1'b1;
         IRQ_N_OUT <= 1'b0;
         IRQ_OE_OUT <= 1'b0;
         RX_16X_CLOCK_PIN_OUT <= 1'b0;
         RX_16X_CLOCK_PIN_OE_OUT <= 1'b0;
      end else begin
         TXD_OUT <= cmd_reg[`CMD_ECHO] ? RXD_IN : tx_line;
         RTS_N_OUT <= (txc == 2'h0);
         DTR_N_OUT <= ~cmd_reg[`CMD_DTR];
         IRQ_N_OUT <= 1'b0;
         IRQ_OE_OUT <= irq_reg;
         RX_16X_CLOCK_PIN_OUT <= gen_tick_reg;
         RX_16X_CLOCK_PIN_OE_OUT <= ctrl_reg[`CTL_RXSRC];
      end
   end
   acia_rx u_rx (
      .clk_in(MCLK_IN),
      .rst_in(RESET_IN),
      .tick_in(rx_tick),
      .rxd_in(RXD_IN),
      .wl_in(wl),
      .par_en_in(cmd_reg[`CMD_PAR_EN]),
      .pmode_in(pmode),
      .done_out(rx_done),
      .data_out(rx_data),
      .ferr_out(rx_ferr),
      .perr_out(rx_perr)
   );
endmodule
`default_nettype wire
